// *** rtl/pfu_pkg.sv ***
// pfu_pkg: constants and types for the function instruction unit
// Operation
// - crc runs over n low bytes of successive source words from s.
// - crc high byte goes to d low byte, low byte to d+1, highs zero.
// - result-zero output is set when the 16-bit crc equals zero.
// - crc byte count outside 1..256 skips work and sets error.
// - crc follows modbus rtu so a good frame plus check yields zero.
// - polarity operand 0 means unipolar module, 1 means bipolar.
// - level conversion turns n source words from s into words at d.
// - conversion does nothing when word count lies outside 1..64.
// - conversion removes 4 ma offset, rescales to 0..4095 or 0..16383.
// - resolution select low picks 12-bit module, high picks 14-bit.
// - xor sets each result bit where sa and sb differ, 16 or 32 bit.
// - bitwise equal sets each result bit where sa and sb agree.
// - after xor or equal op, result-zero flag set when result is zero.
// - zone compare sets in-zone flag when lower <= s <= upper.
// - zone compare sets above-upper flag when s exceeds upper limit.
// - zone compare sets below-lower flag when s is below lower limit.
// - upper below lower sets error and skips the comparison.
// - bit read copies bit n of s to the bit read output.
// - untriggered bit read holds output, or forces zero if select set.
// - bit index beyond 0..15 or 0..31 sets error and skips execution.
package pfu_pkg;
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int CNT_W = 9;
  localparam int IDX_W = 6;
  localparam logic [CNT_W-1:0] CRC_N_MIN = 9'h001;
  localparam logic [CNT_W-1:0] CRC_N_MAX = 9'h100;
  localparam logic [CNT_W-1:0] CNV_N_MIN = 9'h001;
  localparam logic [CNT_W-1:0] CNV_N_MAX = 9'h040;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [5:0] BIT_MAX16 = 6'h0f;
  localparam logic [5:0] BIT_MAX32 = 6'h1f;
  // raw counts: 0..20 ma spans 0..4095 (12-bit) or 0..16383 (14-bit)
  localparam logic [15:0] FS12 = 16'h0fff;
  localparam logic [15:0] FS14 = 16'h3fff;
  localparam logic [15:0] OFS12 = 16'h0333;
  localparam logic [15:0] OFS14 = 16'h0ccc;
  localparam logic [15:0] SPAN12 = 16'h0ccc;
  localparam logic [15:0] SPAN14 = 16'h3333;
  localparam int CRC_BITS = 8;
  typedef enum logic [2:0] {
    PFU_OP_CRC, PFU_OP_CNV, PFU_OP_XOR, PFU_OP_XNR, PFU_OP_ZCP, PFU_OP_BRD
  } pfu_op_t;
endpackage

// *** rtl/pfu_crc_byte.sv ***
// pfu_crc_byte: one byte step of the reflected crc16
`timescale 1ns/1ns
module pfu_crc_byte
  import pfu_pkg::*;
(
  // data in
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  byte_in,
  // data out
  output logic [15:0]      crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, byte_in};
    for (int i = 0; i < CRC_BITS; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule // pfu_crc_byte

// *** rtl/pfu_unit.sv ***
// pfu_unit: function instruction execution unit
`timescale 1ns/1ns
module pfu_unit
  import pfu_pkg::*;
#(
  parameter int ADDR_W = 13
)(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // instruction
  input  wire logic                exec_en,
  input  wire logic                edge_mode,
  input  wire pfu_pkg::pfu_op_t    op_sel,
  input  wire logic                wide_op,
  input  wire logic                polarity_select,
  input  wire logic                res_14bit,
  input  wire logic                bit_read_clear_select,
  // operands
  input  wire logic [ADDR_W-1:0]   src_addr,
  input  wire logic [ADDR_W-1:0]   dst_addr,
  input  wire logic [CNT_W-1:0]    count_n,
  input  wire logic [31:0]         opnd_a,
  input  wire logic [31:0]         opnd_b,
  input  wire logic [31:0]         opnd_c,
  // register space read
  output logic                     rd_req,
  output logic [ADDR_W-1:0]        rd_addr,
  input  wire logic [15:0]         rd_data,
  // register space write
  output logic                     wr_en,
  output logic [ADDR_W-1:0]        wr_addr,
  output logic [15:0]              wr_data,
  // results
  output logic [31:0]              result,
  output logic                     busy,
  output logic                     done,
  output logic                     zero_flag,
  output logic                     err_flag,
  output logic                     in_zone_flag,
  output logic                     above_flag,
  output logic                     below_flag,
  output logic                     bit_read_out
);
  import pfu_pkg::*;

  // ----------------------------------------------------------
  // trigger
  // ----------------------------------------------------------
  typedef enum {PFU_IDLE, PFU_CRC_RD, PFU_CRC_WH, PFU_CRC_WL,
                PFU_CNV_RD, PFU_CNV_WR} pfu_st_t;

  pfu_st_t            st_r, st_nxt;
  logic               en_d_r, en_d_nxt;
  logic               trig;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  logic [ADDR_W-1:0]  sa_r, sa_nxt;
  logic [ADDR_W-1:0]  da_r, da_nxt;
  logic [15:0]        crc_r, crc_nxt;
  logic [15:0]        crc_step;
  logic [15:0]        cnv_val;
  logic               rd_req_r, rd_req_nxt;
  logic [ADDR_W-1:0]  rd_addr_r, rd_addr_nxt;
  logic               wr_en_r, wr_en_nxt;
  logic [ADDR_W-1:0]  wr_addr_r, wr_addr_nxt;
  logic [15:0]        wr_data_r, wr_data_nxt;
  logic [31:0]        res_r, res_nxt;
  logic               done_r, done_nxt;
  logic               zero_r, zero_nxt;
  logic               err_r, err_nxt;
  logic               inz_r, inz_nxt;
  logic               abv_r, abv_nxt;
  logic               blw_r, blw_nxt;
  logic               obit_r, obit_nxt;
  logic               pol_r, pol_nxt;
  logic               res14_r, res14_nxt;
  logic               busy_r, busy_nxt;

  // rising edge only in edge mode; level mode runs each high cycle
  assign trig = edge_mode ? (exec_en & ~en_d_r) : exec_en;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic signed [32:0] sx(input logic [31:0] v,
                                            input logic w);
    sx = w ? {v[31], v} : {{17{v[15]}}, v[15:0]};
  endfunction

  // 4..20 ma rescale; 0..20 ma spans the input, so 4 ma is a fifth of it
  function automatic logic [15:0] cnv(input logic [15:0] raw,
                                      input logic r14);
    logic [15:0] ofs;
    logic [15:0] fs;
    logic [15:0] span;
    logic [31:0] prod;
    ofs = r14 ? OFS14 : OFS12;
    fs = r14 ? FS14 : FS12;
    span = r14 ? SPAN14 : SPAN12;
    prod = 32'h0000_0000;
    if (raw[15] || raw <= ofs) begin
      cnv = 16'h0000;
    end else if (raw >= fs) begin
      cnv = fs;
    end else begin
      prod = (32'(raw - ofs) * 32'(fs)) + 32'(span >> 1);
      cnv = 16'(prod / 32'(span));
    end
  endfunction

  pfu_crc_byte u_crc (
    .crc_in  (crc_r),
    .byte_in (rd_data[7:0]),
    .crc_out (crc_step)
  );

  // the raw reading is treated as unipolar counts; a bipolar module
  // reports half the counts, so it is doubled first
  assign cnv_val = cnv(pol_r ? {rd_data[14:0], 1'b0} : rd_data,
                       res14_r);

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    logic [31:0] x;
    logic [5:0]  bi;
    logic signed [32:0] s_v;
    logic signed [32:0] u_v;
    logic signed [32:0] l_v;
    x = 32'h0000_0000;
    bi = 6'h00;
    s_v = sx(opnd_a, wide_op);
    u_v = sx(opnd_b, wide_op);
    l_v = sx(opnd_c, wide_op);
    st_nxt = st_r;
    en_d_nxt = exec_en;
    cnt_nxt = cnt_r;
    sa_nxt = sa_r;
    da_nxt = da_r;
    crc_nxt = crc_r;
    rd_req_nxt = 1'b0;
    rd_addr_nxt = rd_addr_r;
    wr_en_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    zero_nxt = zero_r;
    err_nxt = err_r;
    inz_nxt = inz_r;
    abv_nxt = abv_r;
    blw_nxt = blw_r;
    obit_nxt = obit_r;
    pol_nxt = pol_r;
    res14_nxt = res14_r;
    unique case (st_r)
      PFU_IDLE: begin
        if (op_sel == PFU_OP_BRD && !trig && bit_read_clear_select) begin
          obit_nxt = 1'b0;
        end
        if (trig) begin
          unique case (op_sel)
            PFU_OP_CRC: begin
              if (count_n < CRC_N_MIN || count_n > CRC_N_MAX) begin
                err_nxt = 1'b1;
                done_nxt = 1'b1;
              end else begin
                err_nxt = 1'b0;
                crc_nxt = CRC_INIT;
                cnt_nxt = count_n;
                sa_nxt = src_addr;
                da_nxt = dst_addr;
                rd_req_nxt = 1'b1;
                rd_addr_nxt = src_addr;
                st_nxt = PFU_CRC_RD;
              end
            end
            PFU_OP_CNV: begin
              if (count_n >= CNV_N_MIN && count_n <= CNV_N_MAX) begin
                cnt_nxt = count_n;
                sa_nxt = src_addr;
                da_nxt = dst_addr;
                pol_nxt = polarity_select;
                res14_nxt = res_14bit;
                rd_req_nxt = 1'b1;
                rd_addr_nxt = src_addr;
                st_nxt = PFU_CNV_RD;
              end
            end
            PFU_OP_XOR, PFU_OP_XNR: begin
              x = opnd_a ^ opnd_b;
              if (op_sel == PFU_OP_XNR) begin
                x = ~x;
              end
              if (!wide_op) begin
                x = {16'h0000, x[15:0]};
              end
              res_nxt = x;
              zero_nxt = (x == 32'h0000_0000);
              done_nxt = 1'b1;
            end
            PFU_OP_ZCP: begin
              if (u_v < l_v) begin
                err_nxt = 1'b1;
              end else begin
                err_nxt = 1'b0;
                inz_nxt = (l_v <= s_v) && (s_v <= u_v);
                abv_nxt = s_v > u_v;
                blw_nxt = s_v < l_v;
              end
              done_nxt = 1'b1;
            end
            PFU_OP_BRD: begin
              bi = opnd_b[5:0];
              if (opnd_b[31:6] != 26'h0 ||
                  bi > (wide_op ? BIT_MAX32 : BIT_MAX16)) begin
                err_nxt = 1'b1;
              end else begin
                err_nxt = 1'b0;
                obit_nxt = opnd_a[bi[4:0]];
              end
              done_nxt = 1'b1;
            end
            default: begin
              err_nxt = 1'b1;
            end
          endcase
        end
      end
      PFU_CRC_RD: begin
        // one byte per cycle; the read is answered in the same cycle that rd_req is high
        crc_nxt = crc_step;
        cnt_nxt = cnt_r - 9'h001;
        sa_nxt = sa_r + 1'b1;
        if (cnt_r == 9'h001) begin
          st_nxt = PFU_CRC_WH;
        end else begin
          rd_req_nxt = 1'b1;
          rd_addr_nxt = sa_r + 1'b1;
        end
      end
      PFU_CRC_WH: begin
        // wait one cycle for the last step to land in crc_r
        wr_en_nxt = 1'b1;
        wr_addr_nxt = da_r;
        wr_data_nxt = {8'h00, crc_r[15:8]};
        res_nxt = {16'h0000, crc_r};
        zero_nxt = (crc_r == 16'h0000);
        st_nxt = PFU_CRC_WL;
      end
      PFU_CRC_WL: begin
        wr_en_nxt = 1'b1;
        wr_addr_nxt = da_r + 1'b1;
        wr_data_nxt = {8'h00, crc_r[7:0]};
        done_nxt = 1'b1;
        st_nxt = PFU_IDLE;
      end
      PFU_CNV_RD: begin
        wr_en_nxt = 1'b1;
        wr_addr_nxt = da_r;
        wr_data_nxt = cnv_val;
        res_nxt = {16'h0000, cnv_val};
        cnt_nxt = cnt_r - 9'h001;
        sa_nxt = sa_r + 1'b1;
        da_nxt = da_r + 1'b1;
        st_nxt = PFU_CNV_WR;
      end
      PFU_CNV_WR: begin
        if (cnt_r == 9'h000) begin
          done_nxt = 1'b1;
          st_nxt = PFU_IDLE;
        end else begin
          rd_req_nxt = 1'b1;
          rd_addr_nxt = sa_r;
          st_nxt = PFU_CNV_RD;
        end
      end
    endcase
    busy_nxt = (st_nxt != PFU_IDLE);
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= PFU_IDLE;
      en_d_r <= 1'b0;
      cnt_r <= '0;
      sa_r <= '0;
      da_r <= '0;
      crc_r <= CRC_INIT;
      rd_req_r <= 1'b0;
      rd_addr_r <= '0;
      wr_en_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= 16'h0000;
      res_r <= 32'h0000_0000;
      done_r <= 1'b0;
      zero_r <= 1'b0;
      err_r <= 1'b0;
      inz_r <= 1'b0;
      abv_r <= 1'b0;
      blw_r <= 1'b0;
      obit_r <= 1'b0;
      pol_r <= 1'b0;
      res14_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      en_d_r <= en_d_nxt;
      cnt_r <= cnt_nxt;
      sa_r <= sa_nxt;
      da_r <= da_nxt;
      crc_r <= crc_nxt;
      rd_req_r <= rd_req_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
      zero_r <= zero_nxt;
      err_r <= err_nxt;
      inz_r <= inz_nxt;
      abv_r <= abv_nxt;
      blw_r <= blw_nxt;
      obit_r <= obit_nxt;
      pol_r <= pol_nxt;
      res14_r <= res14_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign rd_req = rd_req_r;
  assign rd_addr = rd_addr_r;
  assign wr_en = wr_en_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign result = res_r;
  assign busy = busy_r;
  assign done = done_r;
  assign zero_flag = zero_r;
  assign err_flag = err_r;
  assign in_zone_flag = inz_r;
  assign above_flag = abv_r;
  assign below_flag = blw_r;
  assign bit_read_out = obit_r;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_crc_bad_len: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (st_r == PFU_IDLE && trig &&
    op_sel == PFU_OP_CRC && (count_n == 9'h000 || count_n > CRC_N_MAX))
    |=> err_r && st_r == PFU_IDLE)
    else $error("crc length error not flagged");
  a_crc_hi_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (st_r == PFU_CRC_WH) |=> wr_en_r &&
    wr_data_r[15:8] == 8'h00 ##1 wr_en_r &&
    wr_addr_r == $past(wr_addr_r) + 1'b1)
    else $error("crc write pair wrong");
  a_crc_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (st_r == PFU_CRC_WH)
    |=> zero_r == ($past(crc_r) == 16'h0000))
    else $error("crc zero flag wrong");
  a_cnv_bad_len: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (st_r == PFU_IDLE && trig && op_sel == PFU_OP_CNV
    && count_n > CNV_N_MAX) |=> st_r == PFU_IDLE && !wr_en_r)
    else $error("conversion ran on bad length");
  a_cnv_range: assert property (@(posedge ref_clk)
    disable iff (!rst_b) wr_en_r && $past(st_r) == PFU_CNV_RD
    |-> wr_data_r <= (res14_r ? FS14 : FS12))
    else $error("conversion out of range");
  a_xor_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (st_r == PFU_IDLE && trig && op_sel == PFU_OP_XOR
    && !wide_op) |=> res_r[15:0] == ($past(opnd_a[15:0]) ^
    $past(opnd_b[15:0])) && zero_r == (res_r == 32'h0000_0000))
    else $error("xor result or zero flag wrong");
  a_zone_excl: assert property (@(posedge ref_clk)
    disable iff (!rst_b) !err_r && $past(st_r == PFU_IDLE && trig &&
    op_sel == PFU_OP_ZCP) |-> $onehot({inz_r, abv_r, blw_r}))
    else $error("zone flags not exclusive");
  a_brd_hold: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (st_r == PFU_IDLE && !trig && op_sel == PFU_OP_BRD)
    |=> bit_read_out == ($past(bit_read_clear_select) ? 1'b0
                          : $past(obit_r)))
    else $error("bit read idle behaviour wrong");
  a_edge_once: assert property (@(posedge ref_clk)
    disable iff (!rst_b) edge_mode && exec_en && $past(exec_en)
    && $past(rst_b) |-> !trig)
    else $error("edge mode retriggered");
endmodule // pfu_unit

// *** tb/pfu_regspace.sv ***
// pfu_regspace: register space model on the unit's read and write ports
`timescale 1ns/1ns
module pfu_regspace #(
  parameter int ADDR_W = 13
)(
  // clock
  input  wire logic              ref_clk,
  // read side
  input  wire logic              rd_req,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [15:0]       rd_data,
  // write side
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [15:0]       wr_data
);
  logic [15:0] mem [0:(1<<ADDR_W)-1];
  // ----------
  // read answers while the request stands
  // ----------
  // the unit takes rd_data at the edge that ends its request cycle;
  // without a request the lines show the inverse, so a stray sample fails
  assign rd_data = rd_req ? mem[rd_addr] : ~mem[rd_addr];
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule // pfu_regspace

// *** tb/pfu_unit_tb.sv ***
// pfu_unit_tb: self-checking bench for the function instruction unit
`timescale 1ns/1ns
module pfu_unit_tb;
  import pfu_pkg::*;
  // ----------
  // signals
  // ----------
  logic        ref_clk, rst_b, exec_en, edge_mode, wide_op, res_14bit;
  logic        polarity_select, bit_read_clear_select, rd_req, wr_en;
  logic        busy, done, zero_flag, err_flag, in_zone_flag;
  logic        above_flag, below_flag, bit_read_out, e, bz;
  pfu_op_t     op_sel;
  logic [12:0] src_addr, dst_addr, rd_addr, wr_addr;
  logic [8:0]  count_n;
  logic [31:0] opnd_a, opnd_b, opnd_c, result, s, u, l, x;
  logic [15:0] rd_data, wr_data, raw, crc_v;
  logic [7:0]  buf_b [0:257];
  logic [2:0]  f;
  int          fails = 0, compares = 0, cycles = 0, n, c;
  int          lens [4] = '{1, 2, 9, 256};

  pfu_unit pfu_unit_inst (.ref_clk, .rst_b, .exec_en, .edge_mode,
    .op_sel, .wide_op, .polarity_select, .res_14bit,
    .bit_read_clear_select, .src_addr, .dst_addr, .count_n, .opnd_a,
    .opnd_b, .opnd_c, .rd_req, .rd_addr, .rd_data, .wr_en, .wr_addr,
    .wr_data, .result, .busy, .done, .zero_flag, .err_flag,
    .in_zone_flag, .above_flag, .below_flag, .bit_read_out);
  pfu_regspace pfu_regspace_inst (.ref_clk, .rd_req, .rd_addr, .rd_data,
    .wr_en, .wr_addr, .wr_data);

  // ----------
  // helpers
  // ----------
  task automatic chk_word(input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("mismatch t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask

  task automatic chk_bit(input logic ex, input logic got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("mismatch t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask

  task automatic end_of_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      #2;
    end
  endtask

  // md: 0 no done expected, 1 done expected, 2 either
  task automatic fire(input pfu_op_t op, input logic wd, input logic [31:0]
      a, input logic [31:0] b, input logic [31:0] cc, input int md);
    int k;
    op_sel = op;
    wide_op = wd;
    opnd_a = a;
    opnd_b = b;
    opnd_c = cc;
    exec_en = 1'b1;
    tick(1);
    bz = busy;
    exec_en = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < (md == 1 ? 600 : 8)) begin
      tick(1);
      k++;
    end
    if (md < 2) chk_bit(md == 1, done);
  endtask

  // reflected crc, one bit at a time
  function automatic logic [15:0] crc_ref(input int k);
    logic [15:0] r;
    r = 16'hffff;
    for (int j = 0; j < k; j++) begin
      r ^= {8'h00, buf_b[j]};
      repeat (8) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    end
    return r;
  endfunction

  // rounded linear rescale, 4 ma sits at one fifth of full scale
  function automatic logic [15:0] cnv_ref(input logic [15:0] v,
      input logic r14);
    int d, fs, sp;
    fs = r14 ? 16383 : 4095;
    sp = r14 ? 13107 : 3276;
    // negative readings give zero, readings past 20 ma stay at full scale
    d = int'($signed(v)) - (r14 ? 3276 : 819);
    if (d >= sp) return 16'(fs);
    return (d <= 0) ? 16'h0 : 16'((d * fs + sp / 2) / sp);
  endfunction

  task automatic crc_run(input int k);
    logic [15:0] r;
    for (int j = 0; j < k; j++) begin
      pfu_regspace_inst.mem[13'h0100 + j] = {8'($urandom), buf_b[j]};
    end
    r = crc_ref(k);
    src_addr = 13'h0100;
    dst_addr = 13'h1000;
    count_n = 9'(k);
    fire(PFU_OP_CRC, 1'b0, 32'h0, 32'h0, 32'h0, 1);
    tick(1);
    chk_word({24'h0, r[15:8]}, 32'(pfu_regspace_inst.mem[13'h1000]));
    chk_word({24'h0, r[7:0]}, 32'(pfu_regspace_inst.mem[13'h1001]));
    chk_bit(r == 16'h0, zero_flag);
    chk_bit(1'b0, err_flag);
    chk_bit(1'b1, bz);
    chk_bit(1'b0, busy);
  endtask

  task automatic hold_run(input logic em);
    edge_mode = em;
    op_sel = PFU_OP_XOR;
    exec_en = 1'b1;
    c = 0;
    for (int k = 0; k < 9; k++) begin
      if (k == 6) exec_en = 1'b0;
      tick(1);
      c += int'(done === 1'b1);
    end
    edge_mode = 1'b0;
  endtask

  // ----------
  // clock and timeout
  // ----------
  initial begin
    ref_clk = 1'b0;
    forever begin
      #10 ref_clk = ~ref_clk;
    end
  end

  // longest op is a 256 byte crc; the whole run needs well under a thousand
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------
  // main sequence
  // ----------
  initial begin
    {rst_b, exec_en, edge_mode, wide_op, res_14bit} = 5'h00;
    {polarity_select, bit_read_clear_select} = 2'h0;
    op_sel = PFU_OP_XOR;
    {src_addr, dst_addr, count_n} = 35'h0;
    {opnd_a, opnd_b, opnd_c} = 96'h0;
    void'($urandom(38212));
    tick(16);
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      s = $urandom;
      u = (i == 2) ? s : $urandom;
      if (!i[0]) {s[31:16], u[31:16]} = 32'h0;
      fire(PFU_OP_XOR, i[0], s, u, 32'h0, 1);
      chk_word(s ^ u, result);
      chk_bit((s ^ u) == 32'h0, zero_flag);
      l = (i == 3) ? ~s : u;
      x = ~(s ^ l);
      if (!i[0]) x[31:16] = 16'h0;
      fire(PFU_OP_XNR, i[0], s, l, 32'h0, 1);
      chk_word(x, result);
      chk_bit(x == 32'h0, zero_flag);
    end
    for (int i = 0; i < 10; i++) begin
      l = $urandom_range(100, 20000);
      u = l + $urandom_range(0, 5000);
      s = $urandom_range(0, 30000);
      if (i == 0) s = l;
      if (i == 1) s = u;
      if (i == 2) s = l - 1;
      if (i == 3) s = u + 1;
      if (i == 9) u = l - 1;
      f = {in_zone_flag, above_flag, below_flag};
      if (i < 9) f = {l <= s && s <= u, s > u, s < l};
      fire(PFU_OP_ZCP, i[0], s, u, l, 2);
      chk_word(32'(f), 32'({in_zone_flag, above_flag, below_flag}));
      chk_bit(i == 9, err_flag);
    end
    for (int i = 0; i < 8; i++) begin
      s = $urandom;
      u = i[0] ? $urandom_range(0, 31) : $urandom_range(0, 15);
      if (i == 6) u = 32'd16;
      if (i == 7) u = 32'd32;
      e = (i < 6) ? s[u[4:0]] : bit_read_out;
      fire(PFU_OP_BRD, i[0], s, u, 32'h0, i < 6 ? 1 : 2);
      chk_bit(e, bit_read_out);
      chk_bit(i >= 6, err_flag);
    end
    fire(PFU_OP_BRD, 1'b0, 32'hffff, 32'h3, 32'h0, 1);
    tick(3);
    chk_bit(1'b1, bit_read_out);
    bit_read_clear_select = 1'b1;
    tick(3);
    chk_bit(1'b0, bit_read_out);
    hold_run(1'b1);
    chk_word(32'd1, 32'(c));
    hold_run(1'b0);
    chk_word(32'd6, 32'(c));
    foreach (lens[j]) begin
      for (int k = 0; k < lens[j]; k++) buf_b[k] = 8'($urandom);
      crc_run(lens[j]);
    end
    crc_v = crc_ref(6);
    buf_b[6] = crc_v[7:0];
    buf_b[7] = crc_v[15:8];
    crc_run(8);
    chk_bit(1'b1, zero_flag);
    for (int j = 0; j < 2; j++) begin
      count_n = j ? 9'h101 : 9'h000;
      fire(PFU_OP_CRC, 1'b0, 32'h0, 32'h0, 32'h0, 1);
      chk_bit(1'b1, err_flag);
      chk_bit(1'b0, bz);
    end
    src_addr = 13'h0200;
    dst_addr = 13'h0300;
    // pass 2 is a bipolar module: its raw counts are doubled first
    for (int r = 0; r < 3; r++) begin
      res_14bit = (r == 1);
      polarity_select = (r == 2);
      n = (r == 1) ? 64 : 5;
      for (int k = 0; k < n; k++) begin
        raw = 16'($urandom_range(0, r == 1 ? 16383 : 4095));
        if (k == 0) raw = (r == 1) ? 16'h0ccc : 16'h0333;
        if (k == 1) raw = (r == 1) ? 16'h3fff : 16'h0fff;
        if (k == 2) raw = 16'h0064;
        if (k == 3) raw = 16'hf800;
        // keep clear of exact halves, where rounding is a free choice
        if (((raw - (r == 1 ? 16'h0ccc : 16'h0333)) & 16'h3) == 16'h2) raw++;
        pfu_regspace_inst.mem[13'h0200 + k] = raw;
      end
      count_n = 9'(n);
      fire(PFU_OP_CNV, 1'b0, 32'h0, 32'h0, 32'h0, 1);
      tick(1);
      chk_bit(1'b1, bz);
      for (int k = 0; k < n; k++) begin
        raw = pfu_regspace_inst.mem[13'h0200 + k];
        if (r == 2) raw = {raw[14:0], 1'b0};
        chk_word(32'(cnv_ref(raw, r == 1)), 32'(pfu_regspace_inst.mem[13'h0300 + k]));
      end
    end
    polarity_select = 1'b0;
    for (int j = 0; j < 2; j++) begin
      pfu_regspace_inst.mem[13'h0300] = 16'h5a5a;
      count_n = j ? 9'h041 : 9'h000;
      fire(PFU_OP_CNV, 1'b0, 32'h0, 32'h0, 32'h0, 0);
      chk_word(32'h5a5a, 32'(pfu_regspace_inst.mem[13'h0300]));
      chk_bit(1'b0, bz);
    end
    end_of_test();
  end
endmodule // pfu_unit_tb
